// File: src/unb_uart.v
// Serial port with nine-bit modes and all bit-rate generators.
// Assumes a core that writes and reads registers on one clock, and
// a remote node on the asynchronous receive and transmit lines.
//
// Summary of operation
// - Upper mode bit 1, lower 0 selects fixed-rate nine-bit mode.
// - Nine-bit frame: start 0, eight data LSB first, ninth bit, stop 1.
// - Fixed-rate mode: core clock over 32, or over 16 with rate double.
// - Buffer write loads data and transmit ninth bit into shift register.
// - Frame starts at the next bit boundary (sixteenth tick) after the load.
// - Transmit-done flag set when stop bit reaches the line.
// - Without extended mode, frame accepted only if receive-done is clear.
// - With multiprocessor filter set, accept only frames with ninth bit 1.
// - Failed acceptance drops the frame and leaves receive-done alone.
// - Accepted frame fills buffer, receive ninth bit, sets receive-done.
// - Both mode bits set: as fixed mode, rate from timers per direction.
// - Any buffer write transmits; reception needs receive enable set.
// - Shift-register mode runs at core clock over twelve.
// - Timer 1 source: overflow rate times two-to-rate-double over 32.
// - Timer 1 autoreload: core clock over 256 minus reload, same scaling.
// - Timer 2 select bits give Timer 2 to receive or transmit.
// - Timer 2 rate is core clock over 16 times 65536 minus reload.
// - UART timer uses integer, extended and fractional dividers.
// - UART timer rate: clock over 16, 2^dividers, one plus fraction/64.
// - In variable modes, UART timer enable overrides rate double and Timer 2 selects.
`timescale 1ns/1ps
`include "unb_uart_consts.vh"

module unb_uart (
   input wire clk,
   input wire resetn,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire sfr_rd,
   output reg [7:0] sfr_rdata,
   input wire rate_double,
   input wire extended_serial_enable,
   input wire rx_timer2_select,
   input wire tx_timer2_select,
   input wire [3:0] timer_mode_upper,
   input wire [7:0] timer1_reload_value,
   input wire timer1_overflow,
   input wire [7:0] timer2_reload_high,
   input wire [7:0] timer2_reload_low,
   input wire rxd,
   output reg txd
);

   localparam RX_IDLE = 2'b00;
   localparam RX_START = 2'b01;
   localparam RX_DATA = 2'b10;

   reg [7:0] serial_control;
   reg [7:0] rx_buffer;
   reg [7:0] baud_fraction;
   reg [7:0] baud_timer_control;

   wire [1:0] mode = serial_control[`UNB_SC_MODE_UPPER:`UNB_SC_MODE_LOWER];
   wire nine_bit = serial_control[`UNB_SC_MODE_UPPER];
   wire timer_en = baud_fraction[`UNB_BF_TIMER_EN];
   wire buf_wr = sfr_wr && (sfr_addr == `UNB_ADDR_SERIAL_BUFFER);

   // Register reads, answered one cycle after the strobe
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         if (sfr_addr == `UNB_ADDR_SERIAL_CONTROL) begin
            sfr_rdata <= serial_control;
         end else if (sfr_addr == `UNB_ADDR_SERIAL_BUFFER) begin
            sfr_rdata <= rx_buffer;
         end else if (sfr_addr == `UNB_ADDR_BAUD_FRACTION) begin
            sfr_rdata <= baud_fraction & `UNB_BF_READ_MASK;
         end else if (sfr_addr == `UNB_ADDR_BAUD_TIMER_CONTROL) begin
            sfr_rdata <= baud_timer_control;
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end

   // Flags set by the engines; a set beats a same-cycle write
   reg ti_set;
   reg ri_set;
   reg rx_ninth;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         serial_control <= 8'h00;
         baud_fraction <= 8'h00;
         baud_timer_control <= 8'h00;
      end else begin
         if (sfr_wr && sfr_addr == `UNB_ADDR_SERIAL_CONTROL)
            serial_control <= sfr_wdata;
         if (sfr_wr && sfr_addr == `UNB_ADDR_BAUD_FRACTION)
            baud_fraction <= sfr_wdata;
         if (sfr_wr && sfr_addr == `UNB_ADDR_BAUD_TIMER_CONTROL)
            baud_timer_control <= sfr_wdata;
         if (ti_set)
            serial_control[`UNB_SC_TX_DONE] <= 1'b1;
         if (ri_set) begin
            serial_control[`UNB_SC_RX_NINTH] <= rx_ninth;
            serial_control[`UNB_SC_RX_DONE] <= 1'b1;
         end
      end
   end

   // Free half-rate toggle and divide-by-twelve for fixed rates
   reg half;
   reg [3:0] div12;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         half <= 1'b0;
         div12 <= 4'h0;
      end else begin
         half <= ~half;
         div12 <= (div12 == `UNB_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
      end
   end
   wire m0_bit = (div12 == `UNB_DIV12_LAST);
   wire m2_tick = rate_double | half;

   // Timer 1: internal autoreload counter or external overflow
   reg [7:0] t1_cnt;
   reg t1_half;
   wire t1_auto = (timer_mode_upper == `UNB_T1_AUTORELOAD);
   wire t1_wrap = (t1_cnt == 8'hff);
   wire t1_ovf = t1_auto ? t1_wrap : timer1_overflow;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         t1_cnt <= 8'h00;
         t1_half <= 1'b0;
      end else begin
         // Idle counter holds the reload so the first overflow is a full period
         if (t1_auto)
            t1_cnt <= t1_wrap ? timer1_reload_value : t1_cnt + 8'h01;
         else
            t1_cnt <= timer1_reload_value;
         if (t1_ovf)
            t1_half <= ~t1_half;
      end
   end
   wire t1_tick = t1_ovf && (rate_double || t1_half);

   // Timer 2 in bit-rate mode, 16-bit reload
   reg [15:0] t2_cnt;
   wire t2_run = rx_timer2_select | tx_timer2_select;
   wire t2_tick = t2_run && (t2_cnt == 16'hffff);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         t2_cnt <= 16'h0000;
      end else if (t2_run) begin
         t2_cnt <= t2_tick ? {timer2_reload_high, timer2_reload_low}
                           : t2_cnt + 16'h0001;
      end else begin
         // Unselected timer waits at the reload, not at zero
         t2_cnt <= {timer2_reload_high, timer2_reload_low};
      end
   end

   // UART timer: power-of-two prescale, then fractional accumulator
   wire [3:0] ut_shift = {1'b0, baud_timer_control[`UNB_BT_DIV_HI:`UNB_BT_DIV_LO]}
                       + {2'b00, baud_timer_control[`UNB_BT_EXT_HI:`UNB_BT_EXT_LO]};
   wire [7:0] ut_frac = {2'b00, baud_fraction[`UNB_BF_FRAC_HI:`UNB_BF_FRAC_LO]};
   reg [9:0] ut_pre;
   reg [7:0] ut_acc;
   wire [9:0] ut_last = (10'h001 << ut_shift) - 10'h001;
   wire ut_en = (ut_pre == ut_last);
   wire [7:0] ut_sum = ut_acc + `UNB_FRAC_ONE;
   wire ut_tick = ut_en && (ut_sum >= `UNB_FRAC_ONE + ut_frac);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ut_pre <= 10'h000;
         ut_acc <= 8'h00;
      end else if (timer_en) begin
         ut_pre <= ut_en ? 10'h000 : ut_pre + 10'h001;
         if (ut_en)
            ut_acc <= ut_tick ? ut_sum - (`UNB_FRAC_ONE + ut_frac) : ut_sum;
      end else begin
         ut_pre <= 10'h000;
         ut_acc <= 8'h00;
      end
   end

   // Per-direction tick selection, sixteen ticks per bit
   reg tx_tick;
   reg rx_tick;
   always @* begin
      if (mode == `UNB_MODE_FIXED9) begin
         tx_tick = m2_tick;
         rx_tick = m2_tick;
      end else if (timer_en) begin
         tx_tick = ut_tick;
         rx_tick = ut_tick;
      end else begin
         tx_tick = tx_timer2_select ? t2_tick : t1_tick;
         rx_tick = rx_timer2_select ? t2_tick : t1_tick;
      end
   end

   // Transmitter
   reg [3:0] tx_div;
   reg [9:0] tx_sh;
   reg [3:0] tx_left;
   reg tx_pend;
   wire tx_bit = (mode == `UNB_MODE_SHIFT) ? m0_bit
               : (tx_tick && tx_div == `UNB_TICK_LAST);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_div <= 4'h0;
         tx_sh <= 10'h3ff;
         tx_left <= 4'h0;
         tx_pend <= 1'b0;
         txd <= 1'b1;
         ti_set <= 1'b0;
      end else begin
         ti_set <= 1'b0;
         if (tx_tick)
            tx_div <= tx_div + 4'h1;
         if (buf_wr) begin
            // Stop, ninth bit, then data shifted LSB first
            tx_sh <= {1'b1, nine_bit ? serial_control[`UNB_SC_TX_NINTH] : 1'b1,
                      sfr_wdata};
            tx_pend <= 1'b1;
            tx_left <= 4'h0;
            txd <= 1'b1;
         end else if (tx_bit) begin
            if (tx_pend) begin
               txd <= 1'b0;
               tx_pend <= 1'b0;
               tx_left <= nine_bit ? `UNB_TX_BITS_NINE : `UNB_TX_BITS_EIGHT;
            end else if (tx_left != 4'h0) begin
               txd <= tx_sh[0];
               tx_sh <= {1'b1, tx_sh[9:1]};
               tx_left <= tx_left - 4'h1;
               if (tx_left == 4'h1)
                  ti_set <= 1'b1;
            end
         end
      end
   end

   // Receive line synchroniser
   reg rxd_meta;
   reg rxd_s;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxd_meta <= 1'b1;
         rxd_s <= 1'b1;
      end else begin
         rxd_meta <= rxd;
         rxd_s <= rxd_meta;
      end
   end

   // Receiver
   reg [1:0] rx_state;
   reg [3:0] rx_div;
   reg [3:0] rx_n;
   reg [7:0] rx_sh;
   reg rx_armed;
   wire rx_ok = (extended_serial_enable || !serial_control[`UNB_SC_RX_DONE]) &&
                (!serial_control[`UNB_SC_MULTIPROC] || rxd_s);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_state <= RX_IDLE;
         rx_div <= 4'h0;
         rx_n <= 4'h0;
         rx_sh <= 8'h00;
         rx_armed <= 1'b0;
         rx_buffer <= 8'h00;
         rx_ninth <= 1'b0;
         ri_set <= 1'b0;
      end else begin
         ri_set <= 1'b0;
         if (rx_tick) begin
            case (rx_state)
               RX_IDLE: begin
                  rx_div <= 4'h0;
                  if (rxd_s) begin
                     rx_armed <= 1'b1;
                  end else if (rx_armed && mode != `UNB_MODE_SHIFT &&
                               serial_control[`UNB_SC_RX_ENABLE]) begin
                     rx_armed <= 1'b0;
                     rx_state <= RX_START;
                  end
               end
               RX_START: begin
                  rx_div <= rx_div + 4'h1;
                  if (rx_div == `UNB_TICK_MID) begin
                     rx_div <= 4'h0;
                     rx_n <= 4'h0;
                     rx_state <= rxd_s ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  rx_div <= rx_div + 4'h1;
                  if (rx_div == `UNB_TICK_LAST) begin
                     rx_n <= rx_n + 4'h1;
                     if (rx_n == `UNB_RX_LAST_SAMPLE) begin
                        // Final shift pulse: accept or drop whole frame
                        rx_state <= RX_IDLE;
                        if (rx_ok) begin
                           rx_buffer <= rx_sh;
                           rx_ninth <= rxd_s;
                           ri_set <= 1'b1;
                        end
                     end else begin
                        rx_sh <= {rxd_s, rx_sh[7:1]};
                     end
                  end
               end
               default: begin
                  rx_state <= RX_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// File: shared/unb_uart_consts.vh
// Constants for the nine-bit serial port and its rate generators.
// Assumes an eight-bit special-function-register address space.
`ifndef UNB_UART_CONSTS_VH
`define UNB_UART_CONSTS_VH

// Register addresses
`define UNB_ADDR_SERIAL_CONTROL 8'h98
`define UNB_ADDR_SERIAL_BUFFER 8'h99
`define UNB_ADDR_BAUD_FRACTION 8'h9d
`define UNB_ADDR_BAUD_TIMER_CONTROL 8'h9e

// Serial control bit positions
`define UNB_SC_MODE_UPPER 7
`define UNB_SC_MODE_LOWER 6
`define UNB_SC_MULTIPROC 5
`define UNB_SC_RX_ENABLE 4
`define UNB_SC_TX_NINTH 3
`define UNB_SC_RX_NINTH 2
`define UNB_SC_TX_DONE 1
`define UNB_SC_RX_DONE 0

// Mode encodings of the two mode-select bits
`define UNB_MODE_SHIFT 2'h0
`define UNB_MODE_FIXED9 2'h2

// Baud fraction and baud timer control fields
`define UNB_BF_TIMER_EN 7
`define UNB_BF_FRAC_HI 5
`define UNB_BF_FRAC_LO 0
`define UNB_BF_READ_MASK 8'hbf
`define UNB_BT_DIV_HI 2
`define UNB_BT_DIV_LO 0
`define UNB_BT_EXT_HI 4
`define UNB_BT_EXT_LO 3
`define UNB_FRAC_ONE 8'h40

// Timer 1 autoreload mode nibble
`define UNB_T1_AUTORELOAD 4'h2

// Sixteen ticks per bit, mid-bit at tick eight
`define UNB_TICK_LAST 4'hf
`define UNB_TICK_MID 4'h7
// Shift-register mode divides the core clock by twelve
`define UNB_DIV12_LAST 4'hb
// Bits after the start bit: nine-bit and eight-bit frames
`define UNB_TX_BITS_NINE 4'ha
`define UNB_TX_BITS_EIGHT 4'h9
// Index of the last receive sample (ninth bit or stop bit)
`define UNB_RX_LAST_SAMPLE 4'h8

`endif

// File: sim/unb_uart_checker.sv
// Checker: fixed-rate transmit framing and register read-back.
// Assumes it is bound to the serial port top module.
`timescale 1ns/1ps
module unb_uart_checker (
   input wire clk,
   input wire resetn,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_rdata,
   input wire rate_double,
   input wire txd
);
   reg [7:0] ctl_sh, bt_sh, bf_sh, tx_d;
   reg tx_n, armed, txd_q;
   reg [8:0] fcnt;
   wire wr_buf = sfr_wr && sfr_addr == 8'h99;
   wire mode2 = ctl_sh[7:6] == 2'h2;
   wire [4:0] bidx = rate_double ? fcnt[8:4] : {1'b0, fcnt[8:5]};
   wire in_frame = mode2 && !armed && fcnt != 9'h0 && bidx < 5'hb;
   wire [8:0] tx_frame = {tx_d, 1'b0};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Register shadows and clock count since the start bit
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {ctl_sh, bt_sh, bf_sh, tx_d} <= 32'h0;
         {tx_n, armed, txd_q} <= 3'h1;
         fcnt <= 9'h0;
      end else begin
         txd_q <= txd;
         if (sfr_wr && sfr_addr == 8'h98) ctl_sh <= sfr_wdata;
         if (sfr_wr && sfr_addr == 8'h9e) bt_sh <= sfr_wdata;
         if (sfr_wr && sfr_addr == 8'h9d) bf_sh <= sfr_wdata;
         if (wr_buf) begin
            armed <= 1'b1;
            fcnt <= 9'h0;
            tx_d <= sfr_wdata;
            tx_n <= ctl_sh[3];
         end else if (armed && txd_q && !txd) begin
            armed <= 1'b0;
            fcnt <= 9'h1;
         end else if (fcnt != 9'h0 && fcnt != 9'h1ff) begin
            fcnt <= fcnt + 9'h1;
         end
      end
   end
   sequence s_low16;
      (!txd) [*8] ##1 (!txd) [*8];
   endsequence
   sequence s_read(a);
      sfr_rd && sfr_addr == a;
   endsequence
   a_start_wait: assert property (wr_buf && mode2 |=> txd)
      else $error("Frame began on the load edge");
   a_start_bound: assert property (wr_buf && mode2 |-> ##[2:40] !txd)
      else $error("Frame did not begin");
   a_start_len: assert property (mode2 && $fell(txd) |-> s_low16)
      else $error("Low bit shorter than sixteen clocks");
   a_data_bits: assert property (in_frame && bidx < 5'h9 |-> txd == tx_frame[bidx])
      else $error("Wrong start or data bit");
   a_ninth_bit: assert property (in_frame && bidx == 5'h9 |-> txd == tx_n)
      else $error("Wrong ninth bit");
   a_stop_bit: assert property (in_frame && bidx == 5'ha |-> txd)
      else $error("Stop bit not high");
   a_frac_read: assert property (s_read(8'h9d) |=> sfr_rdata == (bf_sh & 8'hbf))
      else $error("Baud fraction read wrong");
   a_baud_read: assert property (s_read(8'h9e) |=> sfr_rdata == bt_sh)
      else $error("Baud timer control read wrong");
   a_mode_read: assert property (s_read(8'h98) |=> sfr_rdata[7:3] == ctl_sh[7:3])
      else $error("Serial control read wrong");
endmodule
bind unb_uart unb_uart_checker unb_uart_checker_inst (.clk(clk), .resetn(resetn),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .rate_double(rate_double), .txd(txd));

// File: sim/unb_remote_node.sv
// Remote serial node: drives nine-bit frames onto the receive line.
// Assumes the core clock and a whole number of clocks per bit.
`timescale 1ns/1ps
module unb_remote_node (
   input wire clk,
   output reg rxd
);
   initial rxd = 1'b1;
   // Start, data LSB first, ninth bit, stop; line idles high
   task send(input [7:0] d, input n, input integer per);
      reg [10:0] f;
      integer i;
      begin
         f = {1'b1, n, d, 1'b0};
         for (i = 0; i < 11; i = i + 1) begin
            @(negedge clk) rxd = f[i];
            repeat (per - 1) @(negedge clk);
         end
      end
   endtask
   // Low pulse too short to be a start bit
   task glitch(input integer len);
      begin
         @(negedge clk) rxd = 1'b0;
         repeat (len) @(negedge clk);
         rxd = 1'b1;
      end
   endtask
endmodule

// File: sim/unb_uart_tb.sv
// Testbench: table of receive cases, then overrun, false start, transmit.
// Assumes the remote node model and the bound checker.
`timescale 1ns/1ps
module unb_uart_tb;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] bf;
      logic [3:0] tm;
      logic [3:0] cfg;
      logic [7:0] d;
      logic n;
      logic acc;
   } unb_row_t;
   unb_row_t rows [0:9];
   reg clk, resetn, sfr_wr, sfr_rd, rate_double, ext_en, t2_sel, t1_ovf;
   reg [7:0] sfr_addr, sfr_wdata, v;
   reg [3:0] tmode;
   reg [7:0] t1_rld;
   reg [15:0] t2_rld;
   wire [7:0] sfr_rdata;
   wire rxd, txd;
   integer error_cnt, n_compared, i, k;
   unb_uart unb_uart_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .rate_double(rate_double), .extended_serial_enable(ext_en),
      .rx_timer2_select(t2_sel), .tx_timer2_select(t2_sel), .timer_mode_upper(tmode),
      .timer1_reload_value(t1_rld), .timer1_overflow(t1_ovf),
      .timer2_reload_high(t2_rld[15:8]), .timer2_reload_low(t2_rld[7:0]),
      .rxd(rxd), .txd(txd));
   unb_remote_node unb_remote_node_inst (.clk(clk), .rxd(rxd));
   task check(input [7:0] seen, input [7:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk) {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
         @(negedge clk) sfr_wr = 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(negedge clk) {sfr_rd, sfr_addr} = {1'b1, a};
         @(negedge clk) sfr_rd = 1'b0;
         v = sfr_rdata;
      end
   endtask
   // Send one frame and compare flags and buffer
   task rx_case(input [7:0] c, input [7:0] d, input n, input acc, input integer per);
      begin
         wr(8'h98, c);
         unb_remote_node_inst.send(d, n, per);
         repeat (24) @(negedge clk);
         rd(8'h98);
         check(v, acc ? (c | 8'h01 | {5'h0, n, 2'h0}) : c);
         rd(8'h99);
         if (acc) check(v, d);
      end
   endtask
   // Transmit one frame and time the done flag from the start bit
   task tx_case(input rdbl, input [7:0] c, input integer per);
      integer nb;
      begin
         // Bits from start to stop: ten in nine-bit modes, nine otherwise
         nb = c[7] ? 10 : 9;
         rate_double = rdbl;
         wr(8'h98, c);
         wr(8'h99, 8'h3a);
         for (k = 0; txd === 1'b1 && k < 80; k = k + 1) @(negedge clk);
         v = 8'h0;
         for (k = 0; v[1] !== 1'b1 && k < 900; k = k + 2) rd(8'h98);
         check(v, c | 8'h02);
         check({6'h0, k >= nb * per && k <= nb * per + 6, txd}, 8'h03);
         repeat (2 * per) @(negedge clk);
      end
   endtask
   task test_done;
      begin
         $display("Compared %0d, errors %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      test_done;
   end
   initial begin
      // cfg holds rate double, Timer 1 overflow, Timer 2 select, spare
      rows[0] = {8'h90, 8'h00, 4'h0, 4'h8, 8'ha5, 1'b0, 1'b1}; // Fixed rate
      rows[1] = {8'hb0, 8'h00, 4'h0, 4'h8, 8'h3c, 1'b0, 1'b0}; // Filter drops
      rows[2] = {8'hb0, 8'h00, 4'h0, 4'h8, 8'hc3, 1'b1, 1'b1}; // Filter passes
      rows[3] = {8'h80, 8'h00, 4'h0, 4'h8, 8'h55, 1'b1, 1'b0}; // Receive off
      rows[4] = {8'hd0, 8'h80, 4'h0, 4'h2, 8'h81, 1'b1, 1'b1}; // UART timer
      rows[5] = {8'hd0, 8'h00, 4'h0, 4'h2, 8'h7e, 1'b0, 1'b1}; // Timer 2
      rows[6] = {8'hd0, 8'h00, 4'h2, 4'h8, 8'h18, 1'b1, 1'b1}; // Timer 1 reload
      rows[7] = {8'hd0, 8'h00, 4'h0, 4'hc, 8'h5a, 1'b0, 1'b1}; // Timer 1 overflow
      rows[8] = {8'hf0, 8'h80, 4'h0, 4'h0, 8'h00, 1'b0, 1'b0}; // Variable, drop
      rows[9] = {8'h90, 8'h80, 4'h0, 4'h0, 8'he7, 1'b1, 1'b1}; // Fixed, slow
      {resetn, sfr_wr, sfr_rd, rate_double, ext_en, t2_sel, t1_ovf} = 7'h0;
      {sfr_addr, sfr_wdata, tmode} = 20'h0;
      {t1_rld, t2_rld} = 24'hffffff;
      error_cnt = 0;
      n_compared = 0;
      repeat (12) @(negedge clk);
      check({7'h0, txd}, 8'h01);
      check(sfr_rdata, 8'h00);
      resetn = 1'b1;
      // Reset values, then read-back and unmapped space
      for (i = 0; i < 4; i = i + 1) begin
         rd(8'h98 + i[7:0] + (i > 1 ? 8'h3 : 8'h0));
         check(v, 8'h00);
      end
      wr(8'h9d, 8'hff);
      rd(8'h9d);
      check(v, 8'hbf);
      wr(8'h9f, 8'h55);
      rd(8'h9f);
      check(v, 8'h00);
      for (i = 0; i < 10; i = i + 1) begin
         @(negedge clk) {rate_double, t1_ovf, t2_sel} = rows[i].cfg[3:1];
         tmode = rows[i].tm;
         wr(8'h9d, rows[i].bf);
         rx_case(rows[i].ctl, rows[i].d, rows[i].n, rows[i].acc,
            (rows[i].ctl[6] || rows[i].cfg[3]) ? 16 : 32);
      end
      // Unread data blocks a frame unless extended mode is on
      {rate_double, t1_ovf, t2_sel} = 3'h4;
      rx_case(8'h90, 8'ha5, 1'b0, 1'b1, 16);
      unb_remote_node_inst.send(8'h66, 1'b1, 16);
      repeat (24) @(negedge clk);
      rd(8'h98);
      check(v, 8'h91);
      rd(8'h99);
      check(v, 8'ha5);
      ext_en = 1'b1;
      unb_remote_node_inst.send(8'h66, 1'b1, 16);
      repeat (24) @(negedge clk);
      rd(8'h98);
      check(v, 8'h95);
      ext_en = 1'b0;
      // A short low pulse must not start a frame
      wr(8'h98, 8'h90);
      unb_remote_node_inst.glitch(4);
      repeat (40) @(negedge clk);
      rd(8'h98);
      check(v, 8'h90);
      rx_case(8'h90, 8'h3c, 1'b0, 1'b1, 16);
      // Timer 2 reload two below wrap: 32 clocks per bit
      {t1_rld, t2_rld} = 24'hfefffe;
      {rate_double, t1_ovf, t2_sel} = 3'h1;
      wr(8'h9d, 8'h00);
      rx_case(8'hd0, 8'h96, 1'b1, 1'b1, 32);
      // Timer 1 autoreload two below wrap, no doubling: 64 clocks per bit
      {rate_double, t1_ovf, t2_sel} = 3'h0;
      tmode = 4'h2;
      rx_case(8'hd0, 8'h69, 1'b0, 1'b1, 64);
      tx_case(1'b1, 8'h88, 16);
      tx_case(1'b0, 8'h88, 32);
      tx_case(1'b0, 8'h08, 12);
      test_done;
   end
endmodule
